// >>> pkg/lstd_pkg.sv
// Summary of operation
// [RL1] B bit picks byte, else word
// [RL2] Post-indexed with W forces non-privileged access
// [RL3] PC base reads plus 8; no write-back
// [RL4] PC-relative is pre-indexed off PC base
// [RL5] Offsets: zero, immediate, or shifted index
// [RL6] Only immediate shift amounts are accepted
// [RL7] Pre-indexed with W writes address back
// [RL8] Pre-indexed without W keeps base unchanged
// [RL9] Post-indexed uses base, then writes sum
// [RL10] Unsigned byte load zero-fills bits 31:8
// [RL11] Failed condition means no effect at all
// [RL12] Half class: half load/store, signed loads
// [RL13] Half class adds or subtracts offset
// [RL14] Half class may write address back
// [RL15] U adds/subtracts; P selects before/after
// [RL16] S/H select unsigned half, signed byte/half
// [RL17] Signed byte replicates bit 7 upward
// [RL18] Signed half replicates bit 15 upward
package lstd_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_INSTR = 8'h00;
    localparam logic [7:0] OFF_BASE = 8'h04;
    localparam logic [7:0] OFF_INDEX = 8'h08;
    localparam logic [7:0] OFF_PC = 8'h0c;
    localparam logic [7:0] OFF_CTRL = 8'h10;
    localparam logic [7:0] OFF_LDATA = 8'h14;
    localparam logic [7:0] OFF_GO = 8'h18;
    localparam logic [7:0] OFF_ADDR = 8'h20;
    localparam logic [7:0] OFF_WBVAL = 8'h24;
    localparam logic [7:0] OFF_STAT = 8'h28;
    localparam logic [7:0] OFF_LRES = 8'h2c;
    // Control fields: flags N Z C V in [3:0], privileged in [4]
    localparam int CTL_PRIV = 4;
    localparam logic [4:0] CTL_RST = 5'h10;
    // Status fields
    localparam int ST_EXEC = 0;
    localparam int ST_WB = 1;
    localparam int ST_LOAD = 2;
    localparam int ST_SIZE = 3;
    localparam int ST_SGN = 5;
    localparam int ST_NPRIV = 6;
    // Pipeline offset of the program counter
    localparam logic [31:0] PC_AHEAD = 32'h8;
    localparam logic [3:0] PC_IDX = 4'hf;
    // Transfer sizes
    typedef enum logic [1:0] {
        LSTD_SZ_BYTE = 2'b00,
        LSTD_SZ_HALF = 2'b01,
        LSTD_SZ_WORD = 2'b10
    } lstd_size_t;
    // Shift kinds
    localparam logic [1:0] SH_LSL = 2'b00;
    localparam logic [1:0] SH_LSR = 2'b01;
    localparam logic [1:0] SH_ASR = 2'b10;
endpackage

// >>> logic/lstd_decode.sv
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module lstd_decode (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Memory request toward the data bus
    output logic mem_req,
    output logic [31:0] mem_addr,
    output lstd_pkg::lstd_size_t mem_size,
    output logic mem_write,
    output logic mem_nonpriv
);
    import lstd_pkg::*;

    ////////////////////////////////////////////////////////////////
    // Helpers

    // Condition code test against N Z C V
    function automatic logic cond_pass(input logic [3:0] c, input logic [3:0] f);
        logic n, z, cy, v;
        n = f[3];
        z = f[2];
        cy = f[1];
        v = f[0];
        case (c)
            4'h0: cond_pass = z;
            4'h1: cond_pass = !z;
            4'h2: cond_pass = cy;
            4'h3: cond_pass = !cy;
            4'h4: cond_pass = n;
            4'h5: cond_pass = !n;
            4'h6: cond_pass = v;
            4'h7: cond_pass = !v;
            4'h8: cond_pass = cy && !z;
            4'h9: cond_pass = !cy || z;
            4'ha: cond_pass = n == v;
            4'hb: cond_pass = n != v;
            4'hc: cond_pass = !z && (n == v);
            4'hd: cond_pass = z || (n != v);
            4'he: cond_pass = 1'b1;
            default: cond_pass = 1'b0;
        endcase
    endfunction

    // Immediate-amount shift; a zero amount means 32 for LSR/ASR, RRX for ROR
    function automatic logic [31:0] shift_imm(input logic [31:0] d, input logic [4:0] a,
                                              input logic [1:0] k, input logic cy);
        logic [63:0] w;
        w = {d, d};
        case (k)
            SH_LSL: shift_imm = d << a;
            SH_LSR: shift_imm = (a == 5'h0) ? 32'h0 : d >> a;
            SH_ASR: shift_imm = (a == 5'h0) ? {32{d[31]}} : $signed(d) >>> a;
            default: shift_imm = (a == 5'h0) ? {cy, d[31:1]} : w[a +: 32];
        endcase
    endfunction

    // Load data extension by size and sign
    function automatic logic [31:0] extend(input logic [31:0] d, input logic [1:0] sz,
                                           input logic s);
        case (sz)
            LSTD_SZ_BYTE: extend = {{24{s & d[7]}}, d[7:0]};
            LSTD_SZ_HALF: extend = {{16{s & d[15]}}, d[15:0]};
            default: extend = d;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////
    // Software-visible storage
    logic [31:0] instr_reg; // Instruction under decode
    logic [31:0] base_val_reg; // Content of the base register
    logic [31:0] idx_val_reg; // Content of the index register
    logic [31:0] pc_reg; // Address of the current instruction
    logic [4:0] ctl_reg; // Flags and privilege
    logic [31:0] ldat_reg; // Lane-steered data returned by memory
    logic [31:0] addr_reg; // Latched access address
    logic [31:0] wbv_reg; // Latched write-back value
    logic [7:0] stat_reg; // Latched decode status
    logic [31:0] lres_reg; // Extended load result
    logic req_reg; // One-cycle memory request
    logic [31:0] prdata_reg;

    ////////////////////////////////////////////////////////////////
    // Instruction fields
    wire [31:0] ins = instr_reg;
    wire pre = ins[24];
    wire up = ins[23];
    wire wbit = ins[21];
    wire ld = ins[20];
    wire base15 = ins[19:16] == PC_IDX;
    wire sd_cls = ins[27:26] == 2'b01;
    // Register-offset half class; S=H=0 is the swap form and is left alone
    wire hw_cls = ins[27:25] == 3'b000 && !ins[22] && ins[7] && ins[4]
                  && ins[6:5] != 2'b00 && ins[11:8] == 4'h0;
    // A register-specified shift amount is refused [RL6]
    wire reg_shift = sd_cls && ins[25] && ins[4];
    // There is no signed store [RL12]
    wire sgn_store = hw_cls && !ld && ins[6];
    wire cond_ok = cond_pass(ins[31:28], ctl_reg[3:0]);
    // Nothing happens unless the predicate holds [RL11]
    wire exec = cond_ok && (sd_cls || hw_cls) && !reg_shift && !sgn_store;

    ////////////////////////////////////////////////////////////////
    // Address generation
    // PC reads eight ahead because of the pipeline [RL3] [RL4]
    wire [31:0] base_eff = base15 ? pc_reg + PC_AHEAD : base_val_reg;
    // Shifted index offset uses the immediate amount only [RL5] [RL6]
    wire [31:0] sh_off = shift_imm(idx_val_reg, ins[11:7], ins[6:5], ctl_reg[1]);
    // Zero is the immediate zero; half class uses the plain index [RL5] [RL13]
    wire [31:0] off = !sd_cls ? idx_val_reg : ins[25] ? sh_off : {20'h0, ins[11:0]};
    // Add when U is set, else subtract [RL15] [RL13]
    wire [31:0] sum = up ? base_eff + off : base_eff - off;
    // Pre-indexed uses the sum, post-indexed the old base [RL15] [RL8] [RL9]
    wire [31:0] acc = pre ? sum : base_eff;
    // Post-indexed always writes back; pre only with W; never the PC [RL7] [RL9] [RL14] [RL3]
    wire wb = !base15 && (!pre || wbit);
    // Size: B bit for words, S/H for the half class [RL1] [RL16]
    wire [1:0] sz = sd_cls ? (ins[22] ? LSTD_SZ_BYTE : LSTD_SZ_WORD)
                           : (ins[5] ? LSTD_SZ_HALF : LSTD_SZ_BYTE);
    wire sgn = hw_cls && ins[6];
    // T form forces a user access; otherwise follow the mode [RL2]
    wire npriv = (sd_cls && !pre && wbit) || !ctl_reg[CTL_PRIV];

    ////////////////////////////////////////////////////////////////
    // APB decode
    wire setup = psel && !penable;
    wire acc_ph = psel && penable;
    wire wr = acc_ph && pwrite;
    wire mapped = paddr inside {OFF_INSTR, OFF_BASE, OFF_INDEX, OFF_PC, OFF_CTRL,
                                OFF_LDATA, OFF_GO, OFF_ADDR, OFF_WBVAL, OFF_STAT, OFF_LRES};
    wire go = wr && paddr == OFF_GO;
    logic [31:0] rd_mux;

    // Read selection; unmapped offsets read zero
    always_comb begin
        case (paddr)
            OFF_INSTR: rd_mux = instr_reg;
            OFF_BASE: rd_mux = base_val_reg;
            OFF_INDEX: rd_mux = idx_val_reg;
            OFF_PC: rd_mux = pc_reg;
            OFF_CTRL: rd_mux = {27'h0, ctl_reg};
            OFF_LDATA: rd_mux = ldat_reg;
            OFF_ADDR: rd_mux = addr_reg;
            OFF_WBVAL: rd_mux = wbv_reg;
            OFF_STAT: rd_mux = {24'h0, stat_reg};
            OFF_LRES: rd_mux = lres_reg;
            default: rd_mux = 32'h0;
        endcase
    end

    // No wait states; unmapped access is flagged, writes to it dropped
    assign pready = 1'b1;
    assign pslverr = acc_ph && !mapped;
    assign prdata = prdata_reg;

    ////////////////////////////////////////////////////////////////
    // Writable registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_reg <= 32'h0;
            base_val_reg <= 32'h0;
            idx_val_reg <= 32'h0;
            pc_reg <= 32'h0;
            ctl_reg <= CTL_RST;
            ldat_reg <= 32'h0;
        end else if (wr) begin
            if (paddr == OFF_INSTR) instr_reg <= pwdata;
            if (paddr == OFF_BASE) base_val_reg <= pwdata;
            if (paddr == OFF_INDEX) idx_val_reg <= pwdata;
            if (paddr == OFF_PC) pc_reg <= pwdata;
            if (paddr == OFF_CTRL) ctl_reg <= pwdata[4:0];
            if (paddr == OFF_LDATA) ldat_reg <= pwdata;
        end
    end

    // Launch: latch decode results and pulse the memory request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_reg <= 32'h0;
            wbv_reg <= 32'h0;
            stat_reg <= 8'h0;
            req_reg <= 1'b0;
        end else begin
            req_reg <= go && exec; // [RL11]
            if (go) begin
                addr_reg <= acc;
                wbv_reg <= wb ? sum : base_val_reg; // [RL8]
                stat_reg <= {1'b0, npriv, sgn, sz, ld, wb && exec, exec};
            end
        end
    end

    // Extended load result and read data, both from flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lres_reg <= 32'h0;
            prdata_reg <= 32'h0;
        end else begin
            // Zero or sign fill by latched size [RL10] [RL17] [RL18]
            lres_reg <= extend(ldat_reg, stat_reg[ST_SIZE +: 2], stat_reg[ST_SGN]);
            if (setup && !pwrite) prdata_reg <= rd_mux;
        end
    end

    // Memory-side view of the latched transfer
    assign mem_req = req_reg;
    assign mem_addr = addr_reg;
    assign mem_size = lstd_size_t'(stat_reg[ST_SIZE +: 2]);
    assign mem_write = !stat_reg[ST_LOAD];
    assign mem_nonpriv = stat_reg[ST_NPRIV];

    ////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_go_sd;
        go && exec && sd_cls;
    endsequence

    property p_size;
        s_go_sd |=> stat_reg[ST_SIZE +: 2] == ($past(ins[22]) ? LSTD_SZ_BYTE : LSTD_SZ_WORD);
    endproperty
    a_size: assert property (p_size) else $error("byte/word size wrong"); // [RL1]

    property p_user;
        s_go_sd ##0 (!pre && wbit) |=> mem_nonpriv;
    endproperty
    a_user: assert property (p_user) else $error("forced user access missing"); // [RL2]

    property p_pcwb;
        go && base15 |=> !stat_reg[ST_WB];
    endproperty
    a_pcwb: assert property (p_pcwb) else $error("write-back with PC base"); // [RL3]

    property p_pcrel;
        s_go_sd ##0 (base15 && pre && up && !ins[25])
            |=> addr_reg == $past(pc_reg) + PC_AHEAD + {20'h0, $past(ins[11:0])};
    endproperty
    a_pcrel: assert property (p_pcrel) else $error("PC-relative address wrong"); // [RL4]

    // The request would show one cycle after the launch edge, so look there
    property p_rshift;
        go && reg_shift |=> !stat_reg[ST_EXEC] && !mem_req;
    endproperty
    a_rshift: assert property (p_rshift) else $error("register shift accepted"); // [RL6]

    property p_prewb;
        go && exec && pre && wbit && !base15 |=> stat_reg[ST_WB] && wbv_reg == addr_reg;
    endproperty
    a_prewb: assert property (p_prewb) else $error("pre-index write-back wrong"); // [RL7]

    property p_prekeep;
        go && pre && !wbit |=> !stat_reg[ST_WB] && wbv_reg == $past(base_val_reg);
    endproperty
    a_prekeep: assert property (p_prekeep) else $error("base changed"); // [RL8]

    property p_post;
        go && exec && !pre && !base15
            |=> addr_reg == $past(base_val_reg) && stat_reg[ST_WB];
    endproperty
    a_post: assert property (p_post) else $error("post-index address wrong"); // [RL9]

    property p_cond;
        go && !cond_ok |=> !mem_req && !stat_reg[ST_EXEC];
    endproperty
    a_cond: assert property (p_cond) else $error("failed predicate executed"); // [RL11]

    property p_nsstore;
        go && hw_cls && !ld && ins[6] |=> !stat_reg[ST_EXEC];
    endproperty
    a_nsstore: assert property (p_nsstore) else $error("signed store executed"); // [RL12]

    // Result lags its inputs by one cycle, so compare against the earlier inputs
    property p_ext;
        stat_reg[ST_SIZE +: 2] == LSTD_SZ_BYTE
            |=> lres_reg[31:8] == {24{$past(stat_reg[ST_SGN]) & $past(ldat_reg[7])}};
    endproperty
    a_ext: assert property (p_ext) else $error("byte fill wrong"); // [RL10]

    property p_half;
        stat_reg[ST_SIZE +: 2] == LSTD_SZ_HALF
            |=> lres_reg[31:16] == {16{$past(stat_reg[ST_SGN]) & $past(ldat_reg[15])}};
    endproperty
    a_half: assert property (p_half) else $error("half fill wrong"); // [RL18]

    // Signed byte: low byte kept, bit 7 copied all the way up
    sequence s_sbyte;
        stat_reg[ST_SIZE +: 2] == LSTD_SZ_BYTE && stat_reg[ST_SGN];
    endsequence

    property p_sbyte;
        s_sbyte |=> lres_reg == {{24{$past(ldat_reg[7])}}, $past(ldat_reg[7:0])};
    endproperty
    a_sbyte: assert property (p_sbyte) else $error("signed byte fill wrong"); // [RL17]

    // Half class launch that is carried out
    sequence s_go_hw;
        go && exec && hw_cls;
    endsequence

    property p_hsize;
        s_go_hw |=> stat_reg[ST_SIZE +: 2] == ($past(ins[5]) ? LSTD_SZ_HALF : LSTD_SZ_BYTE)
            && stat_reg[ST_SGN] == $past(ins[6]);
    endproperty
    a_hsize: assert property (p_hsize) else $error("half class size wrong"); // [RL16]

    property p_hwaddr;
        s_go_hw ##0 (pre && !base15) |=> addr_reg == ($past(up)
            ? $past(base_val_reg) + $past(idx_val_reg)
            : $past(base_val_reg) - $past(idx_val_reg));
    endproperty
    a_hwaddr: assert property (p_hwaddr) else $error("half class address wrong"); // [RL13]

    property p_hwb;
        s_go_hw ##0 (pre && wbit && !base15) |=> stat_reg[ST_WB] && wbv_reg == addr_reg;
    endproperty
    a_hwb: assert property (p_hwb) else $error("half class write-back wrong"); // [RL14]
endmodule

// >>> sim/lstd_mem_model.sv
`timescale 1ns/1ps
module lstd_mem_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Request from the core
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    input wire lstd_pkg::lstd_size_t mem_size,
    input wire logic mem_write,
    input wire logic mem_nonpriv,
    // What the memory saw, for the bench
    output logic [15:0] req_cnt,
    output logic [31:0] seen_addr,
    output lstd_pkg::lstd_size_t seen_size,
    output logic seen_write,
    output logic seen_np,
    // Load word that memory would return
    output logic [31:0] ld_word
);
    import lstd_pkg::*;
    ////////////////////////////////////////////////////////////////
    // Capture each request; a pulse longer than one cycle counts once per cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_cnt <= 16'h0000;
            seen_addr <= 32'h00000000;
            seen_size <= LSTD_SZ_WORD;
            seen_write <= 1'b0;
            seen_np <= 1'b0;
        end else if (mem_req) begin
            req_cnt <= req_cnt + 16'h0001;
            seen_addr <= mem_addr;
            seen_size <= mem_size;
            seen_write <= mem_write;
            seen_np <= mem_nonpriv;
        end
    end
    // Address-scrambled data so sign bits vary from load to load
    assign ld_word = seen_addr ^ 32'h8c4a31f7;
endmodule

// >>> sim/tb_load_store_transfer_decode.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin $display("CHECK FAILED %s exp %0h got %0h", nm, (e), (g)); fails++; end end
module tb_load_store_transfer_decode;
    import lstd_pkg::*;
    // Bus and result signals
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, mem_addr, seen_addr, ld_word;
    logic pready, pslverr, mem_req, mem_write, mem_nonpriv, seen_write, seen_np;
    lstd_size_t mem_size, seen_size, e_sz;
    logic [15:0] req_cnt, cnt0;
    // Operand set and expectations
    int fails = 0;
    int checks_done = 0;
    logic [31:0] base_v, idx_v, pc_v, rd, e_addr, e_wbv, e_stat, i;
    logic [4:0] ctrl_v;
    logic err, e_sg;
    logic [3:0] conds [4] = '{4'he, 4'h0, 4'h1, 4'hf};
    always #12.5 pclk = ~pclk;
    lstd_decode lstd_decode_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_size(mem_size), .mem_write(mem_write),
        .mem_nonpriv(mem_nonpriv));
    lstd_mem_model lstd_mem_model_inst (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_size(mem_size), .mem_write(mem_write),
        .mem_nonpriv(mem_nonpriv), .req_cnt(req_cnt), .seen_addr(seen_addr),
        .seen_size(seen_size), .seen_write(seen_write), .seen_np(seen_np), .ld_word(ld_word));
    ////////////////////////////////////////////////////////////////
    // One APB transfer; the leading edge keeps transfers from colliding
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            fails++;
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Immediate shifts only; a zero amount is never drawn for right shifts
    function automatic logic [31:0] shoff(logic [31:0] v, logic [4:0] a, logic [1:0] k);
        logic [63:0] w;
        w = {v, v} >> a;
        if (k == SH_LSL) return v << a;
        if (k == SH_LSR) return v >> a;
        if (k == SH_ASR) return $signed(v) >>> a;
        return w[31:0];
    endfunction
    function automatic logic condok(logic [3:0] c);
        if (c == 4'he) return 1'b1;
        if (c == 4'h0) return ctrl_v[2];
        if (c == 4'h1) return !ctrl_v[2];
        return 1'b0;
    endfunction
    function automatic logic [31:0] ext(logic [31:0] d, lstd_size_t z, logic s);
        if (z == LSTD_SZ_BYTE) return {{24{s & d[7]}}, d[7:0]};
        if (z == LSTD_SZ_HALF) return {{16{s & d[15]}}, d[15:0]};
        return d;
    endfunction
    ////////////////////////////////////////////////////////////////
    // Expected decode of one instruction
    task automatic calc();
        logic h, ok, wb, np;
        logic [31:0] b, off, sum;
        h = i[27:25] == 3'b000;
        b = (i[19:16] == PC_IDX) ? pc_v + PC_AHEAD : base_v;
        off = h ? idx_v : (i[25] ? shoff(idx_v, i[11:7], i[6:5]) : {20'h0, i[11:0]});
        sum = i[23] ? b + off : b - off;
        e_sz = h ? (i[5] ? LSTD_SZ_HALF : LSTD_SZ_BYTE) : (i[22] ? LSTD_SZ_BYTE : LSTD_SZ_WORD);
        e_sg = h & i[6];
        ok = condok(i[31:28]) & !(e_sg & !i[20]) & !(!h & i[25] & i[4]);
        wb = ok & (!i[24] | i[21]) & (i[19:16] != PC_IDX);
        np = (!h & !i[24] & i[21]) | !ctrl_v[CTL_PRIV];
        e_addr = i[24] ? sum : b;
        e_wbv = wb ? sum : base_v;
        e_stat = {25'h0, np, e_sg, e_sz, i[20], wb, ok};
    endtask
    // Load operands, launch, then compare every result; a refused launch checks only the request count and exec bit
    task automatic run();
        calc();
        apb(1'b1, OFF_INSTR, i);
        apb(1'b1, OFF_BASE, base_v);
        apb(1'b1, OFF_INDEX, idx_v);
        apb(1'b1, OFF_PC, pc_v);
        apb(1'b1, OFF_CTRL, {27'h0, ctrl_v});
        cnt0 = req_cnt;
        apb(1'b1, OFF_GO, 32'h0);
        apb(1'b0, OFF_STAT, 32'h0);
        `CHK("req_count", 16'(cnt0 + e_stat[0]), req_cnt)
        if (e_stat[0] !== 1'b1) `CHK("exec", 1'b0, rd[0])
        else begin
            `CHK("stat", e_stat, rd)
            apb(1'b0, OFF_ADDR, 32'h0);
            `CHK("addr", e_addr, rd)
            `CHK("mem_addr", e_addr, seen_addr)
            `CHK("mem_size", e_sz, seen_size)
            `CHK("mem_write", !i[20], seen_write)
            `CHK("mem_nonpriv", e_stat[6], seen_np)
            apb(1'b0, OFF_WBVAL, 32'h0);
            `CHK("wbval", e_wbv, rd)
            apb(1'b1, OFF_LDATA, ld_word);
            @(posedge pclk);
            apb(1'b0, OFF_LRES, 32'h0);
            `CHK("lres", ext(ld_word, e_sz, e_sg), rd)
        end
    endtask
    ////////////////////////////////////////////////////////////////
    // Verdict and the only end of the run
    task automatic end_of_test();
        if (fails == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Main sequence: reset values, refusals, corners, then random mix
    initial begin
        logic [5:0] f;
        logic [4:0] amt;
        logic [1:0] k;
        void'($urandom(32'haa02));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        `CHK("mem_write_rst", 1'b1, mem_write)
        apb(1'b0, OFF_CTRL, 32'h0);
        `CHK("ctrl_rst", {27'h0, CTL_RST}, rd)
        apb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped_err", 1'b1, err)
        apb(1'b1, OFF_ADDR, 32'hffffffff);
        apb(1'b0, OFF_ADDR, 32'h0);
        `CHK("ro_addr", 32'h0, rd)
        base_v = 32'h00001000;
        idx_v = 32'h00000010;
        pc_v = 32'h00000200;
        ctrl_v = 5'h10;
        // PC-relative load, register shift, signed store, forced user
        i = {4'he, 2'b01, 6'b011001, 4'hf, 4'h1, 12'h010};
        run();
        i = {4'he, 2'b01, 6'b111001, 4'h2, 4'h1, 5'h02, SH_LSL, 1'b1, 4'h3};
        run();
        i = {4'he, 3'b000, 5'b11000, 4'h2, 4'h1, 4'h0, 4'b1101, 4'h3};
        run();
        i = {4'he, 2'b01, 6'b000011, 4'h2, 4'h1, 12'h004};
        run();
        repeat (60) begin
            base_v = $urandom;
            idx_v = $urandom;
            pc_v = $urandom & 32'hfffffffc;
            ctrl_v = 5'($urandom);
            f = 6'($urandom);
            if (f[5]) begin
                k = 2'($urandom % 4);
                amt = 5'($urandom);
                if (k != SH_LSL && amt == 5'h0) amt = 5'h01;
                i = {conds[$urandom % 4], 2'b01, f[0], f[1], f[2], f[3], f[4], 1'($urandom),
                    ($urandom % 4 == 0) ? 4'hf : 4'($urandom), 4'($urandom),
                    f[0] ? {amt, k, 1'b0, 4'($urandom)} : 12'($urandom)};
            end else begin
                k = 2'($urandom % 3 + 1);
                i = {conds[$urandom % 4], 3'b000, f[1], f[2], 1'b0, f[3] & f[1], f[4],
                    4'($urandom), 4'($urandom), 4'h0, 1'b1, k, 1'b1, 4'($urandom)};
            end
            run();
        end
        end_of_test();
    end
endmodule
